// File: verilog/rfa_bank.sv
// What this block does
// (R1) Read-clear field returns its value, then hardware clears it to zero.
// (R2) Software writes a read-only field's reset value; writes are ignored anyway.
// (R3) Read-write field holds and returns the last written value.
// (R4) Any write to a write-any-clear register clears it.
// (R5) Write one clears that bit only; zero leaves it; others keep values.
// (R6) Write-only clear-on-one bit clears on one; reads meaningless.
// (R7) Write-one-set field ignores written zeros.
// (R8) Writing back read status clears only those; later events stay pending.
// (R9) Software preserves reserved bits; hardware reads them as zero.
// (R10) Offset is added to the bank's base address for decoding.
// (R11) Chip reset loads each field's documented reset value.
// (R12) Write-only register acts only on writes; read data meaningless.
// (R13) Write one to set bit sets it; other bits unaffected.
module rfa_bank #(
  parameter logic [31:0] BASE_ADDR = 32'h4000_0000
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              ce,
  input  wire rfa_pkg::rfa_req_s req,
  input  wire logic [31:0]       ev_rc,
  input  wire logic [31:0]       ev_rwc,
  input  wire logic [31:0]       ev_w1c,
  input  wire logic [31:0]       ro_val,
  output logic      [31:0]       rdata,
  output logic                   rvalid,
  output logic                   err,
  output logic      [31:0]       rw_out,
  output logic      [31:0]       w1s_out,
  output logic      [31:0]       wo_out
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [31:0] rel;
  logic        in_win;
  logic [rfa_pkg::NUM_REGS-1:0] hit;
  logic [31:0] vals [rfa_pkg::NUM_REGS];

  // Offset relative to the base; window is 4 KB
  assign rel    = req.addr - BASE_ADDR;                          // see (R10)
  assign in_win = (rel[31:12] == 20'h00000);

  always_comb begin
    hit = '0;
    if (in_win && rel[1:0] == 2'h0) begin
      unique case (rel[11:0])
        rfa_pkg::OFS_RC:  hit[rfa_pkg::IDX_RC]  = 1'b1;
        rfa_pkg::OFS_RO:  hit[rfa_pkg::IDX_RO]  = 1'b1;
        rfa_pkg::OFS_RW:  hit[rfa_pkg::IDX_RW]  = 1'b1;
        rfa_pkg::OFS_RWC: hit[rfa_pkg::IDX_RWC] = 1'b1;
        rfa_pkg::OFS_W1C: hit[rfa_pkg::IDX_W1C] = 1'b1;
        rfa_pkg::OFS_W1S: hit[rfa_pkg::IDX_W1S] = 1'b1;
        rfa_pkg::OFS_WO:  hit[rfa_pkg::IDX_WO]  = 1'b1;
        default:          hit = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  localparam rfa_pkg::rfa_kind_e KINDS [rfa_pkg::NUM_REGS] = '{
    rfa_pkg::RFA_RC, rfa_pkg::RFA_RO, rfa_pkg::RFA_RW, rfa_pkg::RFA_RWC,
    rfa_pkg::RFA_W1C, rfa_pkg::RFA_W1S, rfa_pkg::RFA_WO};
  localparam logic [31:0] RSTS [rfa_pkg::NUM_REGS] = '{
    rfa_pkg::RST_RC, rfa_pkg::RST_RO, rfa_pkg::RST_RW, rfa_pkg::RST_RWC,
    rfa_pkg::RST_W1C, rfa_pkg::RST_W1S, rfa_pkg::RST_WO};
  localparam logic [31:0] MASKS [rfa_pkg::NUM_REGS] = '{
    32'hFFFF_FFFF, 32'hFFFF_FFFF, rfa_pkg::MASK_RW, 32'hFFFF_FFFF,
    32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF};

  logic [31:0] sets [rfa_pkg::NUM_REGS];
  always_comb begin
    for (int i = 0; i < rfa_pkg::NUM_REGS; i++) sets[i] = 32'h0000_0000;
    sets[rfa_pkg::IDX_RC]  = ev_rc;
    sets[rfa_pkg::IDX_RWC] = ev_rwc;
    sets[rfa_pkg::IDX_W1C] = ev_w1c;
    sets[rfa_pkg::IDX_WO]  = ev_w1c;
  end

  // One register instance per entry; read-only ignores writes (see (R2))
  for (genvar g = 0; g < rfa_pkg::NUM_REGS; g++) begin : g_reg
    rfa_field #(
      .KIND (KINDS[g]),
      .RST  (RSTS[g]),
      .MASK (MASKS[g])
    ) u_fld (
      .clk    (clk),
      .reset  (reset),
      .ce     (ce),
      .rd_hit (hit[g] & req.rd & ~req.wr),
      .wr_hit (hit[g] & req.wr),
      .wdata  (req.wdata),
      .hw_set (sets[g]),
      .hw_val (ro_val),
      .value  (vals[g])
    );
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [31:0] rdata_r, rdata_nxt;
  logic        rvalid_r, rvalid_nxt, err_r, err_nxt;

  // Read returns pre-clear value; write-only reads meaningless zero
  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    err_nxt    = 1'b0;
    if (req.rd && !req.wr) begin
      rvalid_nxt = 1'b1;
      err_nxt    = ~|hit;
      rdata_nxt  = 32'h0000_0000;                                // see (R9)
      for (int i = 0; i < rfa_pkg::NUM_REGS; i++)
        if (hit[i]) rdata_nxt = vals[i] & MASKS[i];              // see (R1)
      if (hit[rfa_pkg::IDX_WO]) rdata_nxt = rfa_pkg::RD_MEANINGLESS; // see (R6) see (R12)
    end else if (req.wr) begin
      err_nxt = ~|hit;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r  <= 32'h0000_0000;
      rvalid_r <= 1'b0;
      err_r    <= 1'b0;
    end else if (ce) begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      err_r    <= err_nxt;
    end
  end

  assign rdata   = rdata_r;
  assign rvalid  = rvalid_r;
  assign err     = err_r;
  assign rw_out  = vals[rfa_pkg::IDX_RW];
  assign w1s_out = vals[rfa_pkg::IDX_W1S];
  assign wo_out  = vals[rfa_pkg::IDX_WO];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic rd_rc, wr_w1c, wr_rwc, wr_w1s, wr_rw, rd_rw, rd_wo, wr_wo;
  assign rd_rc  = ce & req.rd & ~req.wr & hit[rfa_pkg::IDX_RC];
  assign rd_rw  = ce & req.rd & ~req.wr & hit[rfa_pkg::IDX_RW];
  assign rd_wo  = ce & req.rd & ~req.wr & hit[rfa_pkg::IDX_WO];
  assign wr_w1c = ce & req.wr & hit[rfa_pkg::IDX_W1C];
  assign wr_rwc = ce & req.wr & hit[rfa_pkg::IDX_RWC];
  assign wr_w1s = ce & req.wr & hit[rfa_pkg::IDX_W1S];
  assign wr_rw  = ce & req.wr & hit[rfa_pkg::IDX_RW];
  assign wr_wo  = ce & req.wr & hit[rfa_pkg::IDX_WO];

  property p_rc_read;
    @(posedge clk) disable iff (reset)
    rd_rc |=> (rdata == $past(vals[rfa_pkg::IDX_RC])) && (vals[rfa_pkg::IDX_RC] == $past(ev_rc));
  endproperty
  a_rc_read: assert property (p_rc_read) else $error("read-clear field not returned then cleared"); // see (R1)

  property p_rw_hold;
    @(posedge clk) disable iff (reset)
    wr_rw ##1 !wr_rw ##1 rd_rw
      |=> rdata == ($past(req.wdata, 3) & rfa_pkg::MASK_RW);
  endproperty
  a_rw_hold: assert property (p_rw_hold) else $error("read-write field lost its value"); // see (R3)

  property p_rw_write;
    @(posedge clk) disable iff (reset)
    wr_rw |=> rw_out == ($past(req.wdata) & rfa_pkg::MASK_RW);
  endproperty
  a_rw_write: assert property (p_rw_write) else $error("read-write field did not take the write"); // see (R3)

  property p_rwc_clear;
    @(posedge clk) disable iff (reset)
    wr_rwc |=> vals[rfa_pkg::IDX_RWC] == $past(ev_rwc);
  endproperty
  a_rwc_clear: assert property (p_rwc_clear) else $error("write-any-clear did not clear"); // see (R4)

  property p_w1c;
    @(posedge clk) disable iff (reset)
    wr_w1c |=> vals[rfa_pkg::IDX_W1C] ==
      (($past(vals[rfa_pkg::IDX_W1C]) & ~$past(req.wdata)) | $past(ev_w1c));
  endproperty
  a_w1c: assert property (p_w1c) else $error("write-one-clear bits wrong"); // see (R5)

  property p_w1c_pending;
    @(posedge clk) disable iff (reset)
    ce |=> (vals[rfa_pkg::IDX_W1C] & $past(ev_w1c)) == $past(ev_w1c);
  endproperty
  a_w1c_pending: assert property (p_w1c_pending) else $error("new event lost"); // see (R8)

  property p_w1s;
    @(posedge clk) disable iff (reset)
    wr_w1s |=> vals[rfa_pkg::IDX_W1S] == ($past(vals[rfa_pkg::IDX_W1S]) | $past(req.wdata));
  endproperty
  a_w1s: assert property (p_w1s) else $error("write-one-set bits wrong"); // see (R7) see (R13)

  property p_wo_read;
    @(posedge clk) disable iff (reset)
    rd_wo |=> rvalid && rdata == rfa_pkg::RD_MEANINGLESS &&
      ($stable(vals[rfa_pkg::IDX_WO]) || |$past(ev_w1c));
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("write-only register changed on read"); // see (R6) see (R12)

  property p_wo_write;
    @(posedge clk) disable iff (reset)
    wr_wo |=> wo_out == (($past(wo_out) & ~$past(req.wdata)) | $past(ev_w1c));
  endproperty
  a_wo_write: assert property (p_wo_write) else $error("write-only clear bits wrong"); // see (R6)

  property p_rw_rsvd;
    @(posedge clk) disable iff (reset)
    rd_rw |=> rdata[31:16] == 16'h0000;
  endproperty
  a_rw_rsvd: assert property (p_rw_rsvd) else $error("reserved bits not zero"); // see (R9)

  property p_reset;
    @(posedge clk) reset |=> vals[rfa_pkg::IDX_RW] == rfa_pkg::RST_RW && !rvalid;
  endproperty
  a_reset: assert property (p_reset) else $error("reset value not loaded"); // see (R11)

  property p_unmapped;
    @(posedge clk) disable iff (reset)
    (ce && (req.rd || req.wr) && !in_win) |=> err;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("out-of-window access not flagged"); // see (R10)

endmodule

// File: verilog/rfa_pkg.sv
package rfa_pkg;

  // ----------------------------------------------------------------
  // Register map of the demonstration bank
  // ----------------------------------------------------------------
  // Offsets are byte increments added to the bank's base address
  localparam logic [11:0] OFS_RC   = 12'h000;
  localparam logic [11:0] OFS_RO   = 12'h004;
  localparam logic [11:0] OFS_RW   = 12'h008;
  localparam logic [11:0] OFS_RWC  = 12'h00C;
  localparam logic [11:0] OFS_W1C  = 12'h010;
  localparam logic [11:0] OFS_W1S  = 12'h014;
  localparam logic [11:0] OFS_WO   = 12'h018;
  localparam int          NUM_REGS = 7;
  localparam int          IDX_RC   = 0;
  localparam int          IDX_RO   = 1;
  localparam int          IDX_RW   = 2;
  localparam int          IDX_RWC  = 3;
  localparam int          IDX_W1C  = 4;
  localparam int          IDX_W1S  = 5;
  localparam int          IDX_WO   = 6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_RC   = 32'h0000_0000;
  localparam logic [31:0] RST_RO   = 32'h0000_0000;
  localparam logic [31:0] RST_RW   = 32'h0000_0000;
  localparam logic [31:0] RST_RWC  = 32'h0000_0000;
  localparam logic [31:0] RST_W1C  = 32'h0000_0000;
  localparam logic [31:0] RST_W1S  = 32'h0000_0000;
  localparam logic [31:0] RST_WO   = 32'h0000_0000;
  // Reserved bits of the read/write register (upper half) read zero
  localparam logic [31:0] MASK_RW  = 32'h0000_FFFF;
  localparam logic [31:0] RD_MEANINGLESS = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rfa_req_s;

  typedef enum logic [2:0] {
    RFA_RC, RFA_RO, RFA_RW, RFA_RWC, RFA_W1C, RFA_W1S, RFA_WO
  } rfa_kind_e;

endpackage

// File: verilog/rfa_field.sv
// ------------------------------------------------------------------
// One register of configurable access kind
// ------------------------------------------------------------------
module rfa_field #(
  parameter rfa_pkg::rfa_kind_e KIND  = rfa_pkg::RFA_RW,
  parameter logic [31:0]        RST   = 32'h0000_0000,
  parameter logic [31:0]        MASK  = 32'hFFFF_FFFF
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        rd_hit,
  input  wire logic        wr_hit,
  input  wire logic [31:0] wdata,
  input  wire logic [31:0] hw_set,
  input  wire logic [31:0] hw_val,
  output logic      [31:0] value
);

  logic [31:0] val_r;
  logic [31:0] val_nxt;

  // Next value by access kind; hardware events win over software clears
  always_comb begin
    val_nxt = val_r;
    unique case (KIND)
      rfa_pkg::RFA_RC: begin
        if (rd_hit) val_nxt = 32'h0000_0000;                  // see (R1)
        val_nxt = val_nxt | hw_set;
      end
      rfa_pkg::RFA_RO:  val_nxt = hw_val;                       // writes ignored
      rfa_pkg::RFA_RW: begin
        if (wr_hit) val_nxt = wdata & MASK;                     // see (R3)
      end
      rfa_pkg::RFA_RWC: begin
        if (wr_hit) val_nxt = 32'h0000_0000;                    // see (R4)
        val_nxt = val_nxt | hw_set;
      end
      rfa_pkg::RFA_W1C, rfa_pkg::RFA_WO: begin
        if (wr_hit) val_nxt = val_r & ~wdata;                   // see (R5) see (R6) see (R8)
        val_nxt = val_nxt | hw_set;
      end
      rfa_pkg::RFA_W1S: begin
        if (wr_hit) val_nxt = val_r | wdata;                    // see (R7) see (R13)
      end
    endcase
  end

  // Register, frozen while the clock enable is low and reset is not asserted
  always_ff @(posedge clk) begin
    if (reset) val_r <= RST;                                    // see (R11)
    else if (ce) val_r <= val_nxt;
  end

  assign value = val_r;

endmodule

// File: verif/rfa_bank_tb.sv
module rfa_bank_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  // A base other than the default shows that decoding follows the parameter
  localparam logic [31:0] BASE = 32'h2000_0000;
  logic              clk;
  logic              reset;
  logic              ce;
  rfa_pkg::rfa_req_s req;
  logic [31:0]       ev_rc;
  logic [31:0]       ev_rwc;
  logic [31:0]       ev_w1c;
  logic [31:0]       ro_val;
  logic [31:0]       rdata;
  logic              rvalid;
  logic              err;
  logic [31:0]       rw_out;
  logic [31:0]       w1s_out;
  logic [31:0]       wo_out;
  logic [31:0]       q;
  logic              e;
  int                miscompares;
  int                total_checks;

  rfa_bank #(.BASE_ADDR(BASE)) rfa_bank_inst (
    .clk(clk), .reset(reset), .ce(ce), .req(req), .ev_rc(ev_rc), .ev_rwc(ev_rwc),
    .ev_w1c(ev_w1c), .ro_val(ro_val), .rdata(rdata), .rvalid(rvalid), .err(err),
    .rw_out(rw_out), .w1s_out(w1s_out), .wo_out(wo_out)
  );

  // 100 MHz clock
  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Case equality, so an unknown never counts as a match
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Starts one edge later so req never changes twice in one time step
  task automatic acc(input logic r, input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    #1 req = '{rd: r, wr: w, addr: a, wdata: d};
    @(posedge clk);
    #1 req = '0;
    while (r && rvalid !== 1'b1 && err !== 1'b1 && n < 2) begin
      @(posedge clk);
      #1 n++;
    end
    q = rdata;
    e = err;
    chk("read valid", {31'h0, r}, {31'h0, rvalid});
  endtask

  task automatic rd(input logic [11:0] ofs);
    acc(1'b1, 1'b0, BASE + {20'h00000, ofs}, 32'h0000_0000);
  endtask

  task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
    acc(1'b0, 1'b1, BASE + {20'h00000, ofs}, d);
  endtask

  // One-cycle hardware event pulses
  task automatic ev(input logic [31:0] rc, input logic [31:0] rwc, input logic [31:0] w1c);
    @(posedge clk);
    #1 {ev_rc, ev_rwc, ev_w1c} = {rc, rwc, w1c};
    @(posedge clk);
    #1 {ev_rc, ev_rwc, ev_w1c} = '0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [11:0] offs [5];
    offs = '{rfa_pkg::OFS_RC, rfa_pkg::OFS_RW, rfa_pkg::OFS_RWC, rfa_pkg::OFS_W1C, rfa_pkg::OFS_W1S};
    foreach (offs[i]) begin
      rd(offs[i]);
      chk("reset read", 32'h0000_0000, q);
    end
    chk("reset outputs", 32'h0000_0000, rw_out | w1s_out | wo_out);
  endtask

  // Software keeps the reserved upper half exactly as it read it
  task automatic t_rw();
    rd(rfa_pkg::OFS_RW);
    wr(rfa_pkg::OFS_RW, {q[31:16], 16'hFFFF});
    rd(rfa_pkg::OFS_RW);
    chk("rw reserved", 32'h0000_FFFF & rfa_pkg::MASK_RW, q);
    wr(rfa_pkg::OFS_RW, {q[31:16], 16'h5A3C});
    rd(rfa_pkg::OFS_RW);
    chk("rw read", 32'h0000_5A3C, q);
    chk("rw out", 32'h0000_5A3C, rw_out);
  endtask

  task automatic t_rc();
    ev(32'h0000_0005, 32'h0, 32'h0);
    rd(rfa_pkg::OFS_RC);
    chk("rc first", 32'h0000_0005, q);
    rd(rfa_pkg::OFS_RC);
    chk("rc second", 32'h0000_0000, q);
  endtask

  task automatic t_ro();
    @(posedge clk);
    #1 ro_val = 32'h1234_5678;
    wr(rfa_pkg::OFS_RO, rfa_pkg::RST_RO);
    rd(rfa_pkg::OFS_RO);
    chk("ro read", 32'h1234_5678, q);
  endtask

  // Zero data is the awkward case for a clear-on-any-write register
  task automatic t_rwc();
    ev(32'h0, 32'h0000_00F0, 32'h0);
    rd(rfa_pkg::OFS_RWC);
    chk("rwc read", 32'h0000_00F0, q);
    wr(rfa_pkg::OFS_RWC, 32'h0000_0000);
    rd(rfa_pkg::OFS_RWC);
    chk("rwc cleared", 32'h0000_0000, q);
  endtask

  // Write back what was read while a later event is pending
  task automatic t_w1c();
    ev(32'h0, 32'h0, 32'h0000_0003);
    rd(rfa_pkg::OFS_W1C);
    chk("w1c status", 32'h0000_0003, q);
    ev(32'h0, 32'h0, 32'h0000_0004);
    wr(rfa_pkg::OFS_W1C, q);
    rd(rfa_pkg::OFS_W1C);
    chk("w1c later event", 32'h0000_0004, q);
    wr(rfa_pkg::OFS_W1C, 32'h0000_0000);
    rd(rfa_pkg::OFS_W1C);
    chk("w1c zero write", 32'h0000_0004, q);
  endtask

  // WO collects the same events; its read data is never judged
  task automatic t_wo();
    rd(rfa_pkg::OFS_WO);
    chk("wo after read", 32'h0000_0007, wo_out);
    wr(rfa_pkg::OFS_WO, 32'h0000_0001);
    chk("wo clear one", 32'h0000_0006, wo_out);
    wr(rfa_pkg::OFS_WO, 32'h0000_0000);
    chk("wo zero write", 32'h0000_0006, wo_out);
  endtask

  task automatic t_w1s();
    wr(rfa_pkg::OFS_W1S, 32'h0000_0011);
    chk("w1s set", 32'h0000_0011, w1s_out);
    wr(rfa_pkg::OFS_W1S, 32'h0000_0000);
    chk("w1s zero write", 32'h0000_0011, w1s_out);
    wr(rfa_pkg::OFS_W1S, 32'h0000_0100);
    rd(rfa_pkg::OFS_W1S);
    chk("w1s read", 32'h0000_0111, q);
  endtask

  task automatic t_dec();
    acc(1'b1, 1'b0, BASE + 32'h0000_001C, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    acc(1'b1, 1'b0, 32'h0000_0008, 32'h0);
    chk("no base err", 32'h1, {31'h0, e});
    acc(1'b0, 1'b1, BASE + 32'h0000_0009, 32'hFFFF_FFFF);
    chk("unaligned err", 32'h1, {31'h0, e});
    chk("rw untouched", 32'h0000_5A3C, rw_out);
  endtask

  // A write while the clock enable is low must leave every register alone
  task automatic t_ce();
    @(posedge clk);
    #1 ce = 1'b0;
    wr(rfa_pkg::OFS_RW, 32'h0000_0000);
    chk("frozen rw", 32'h0000_5A3C, rw_out);
    chk("frozen err", 32'h0, {31'h0, e});
    @(posedge clk);
    #1 ce = 1'b1;
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    {clk, reset, ce} = 3'b011;
    req = '0;
    {ev_rc, ev_rwc, ev_w1c, ro_val} = '0;
    {miscompares, total_checks} = '0;
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
    t_reset();
    t_rw();
    t_rc();
    t_ro();
    t_rwc();
    t_w1c();
    t_wo();
    t_w1s();
    t_dec();
    t_ce();
    tally_and_finish();
  end

  // About 80 cycles are expected; a hang is cut off well beyond that
  initial begin
    #50000;
    miscompares++;
    tally_and_finish();
  end
endmodule
